// file: tadc_params.svh
// constants of the touch acquisition controller: frame layout, register
// addresses, fields, reset values and timing counts. assumes a 100 MHz core clock.
//
// Contract
// [RULE1] mux codes: plates 0-2, aux 3-5, battery 6-7
// [RULE2] aux pins may act as logic pins
// [RULE3] pen touch output active low, pulled up
// [RULE4] select low starts conversion, enables shifter
// [RULE5] serial input sampled on clock rising edge
// [RULE6] no sampling while acquisition halt active
// [RULE7] one dedicated two-way logic pin
// [RULE8] alert low on logic bit or limit fault
// [RULE9] ready low after new result stored
// [RULE10] ready output floats while select high
// [RULE11] output shifts on falling edge, floats deselected
// [RULE12] host alone supplies the serial clock
// [RULE13] every result is twelve bits
// [RULE14] eleven result registers, one per quantity
// [RULE15] aux one and batteries checked against limits
// [RULE16] result averages one to sixteen conversions
// [RULE17] automatic sequencer or host-chosen channel
// [RULE18] programmable power-up delay and acquisition time
// [RULE19] internal timer restarts conversions periodically
// [RULE20] serial bus is the only configuration path
// [RULE21] frame: write bit, five address, twelve data
`ifndef TADC_PARAMS_SVH
`define TADC_PARAMS_SVH
`define TADC_FRAME_BITS 18
`define TADC_HDR_BITS 6
`define TADC_DATA_W 12
`define TADC_ADDR_W 5
`define TADC_A_CTRL 5'h00
`define TADC_A_TIMING 5'h01
`define TADC_A_TIMER 5'h02
`define TADC_A_GPIO 5'h03
`define TADC_A_LIM 5'h04
`define TADC_A_ALERT 5'h0c
`define TADC_A_RES 5'h10
`define TADC_NUM_RES 11
`define TADC_NUM_LIM 4
`define TADC_AUTO_BIT 0
`define TADC_CHAN_LSB 1
`define TADC_AVG_LSB 5
`define TADC_TMR_BIT 8
`define TADC_AVG_MAX 3'h4
`define TADC_CH_XP 4'h0
`define TADC_CH_YP 4'h1
`define TADC_CH_YN 4'h2
`define TADC_CH_AUX1 4'h3
`define TADC_CH_AUX2 4'h4
`define TADC_CH_AUX3 4'h5
`define TADC_CH_BATTERY_IN_ONE 4'h6
`define TADC_CH_BATTERY_IN_TWO 4'h7
`define TADC_CH_TEMPERATURE_ONE 4'h8
`define TADC_CH_TEMP0 4'h9
`define TADC_CH_Z1 4'ha
`define TADC_CH_LAST 4'ha
`define TADC_CTRL_RST 12'h000
`define TADC_TIMING_RST 12'h041
`define TADC_TIMER_RST 12'h064
`define TADC_GPIO_RST 12'h000
`define TADC_LIM_HI_RST 12'hfff
`define TADC_LIM_LO_RST 12'h000
`define TADC_CLK_NS 10
`define TADC_TICK_NS 1000
`define TADC_TICK_CYC (`TADC_TICK_NS / `TADC_CLK_NS)
`endif

// file: tadc_pkg.sv
// types shared by the touch acquisition controller modules.
// assumes tadc_params.svh for the numeric constants.
package tadc_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PWRUP = 5'b00010,
    ST_ACQ = 5'b00100,
    ST_CONV = 5'b01000,
    ST_STORE = 5'b10000
  } tadc_state_type;
endpackage : tadc_pkg

// file: tadc_serial_if.sv
// serial slave of the touch acquisition controller.
// assumes select, clock and data come from pins asynchronous to core_clk.
`timescale 1ns/1ps
`include "tadc_params.svh"
module tadc_serial_if (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  output logic sdo,
  output logic sdo_oe,
  // core side
  output logic cs_active,
  output logic frame_start,
  output logic wr_pulse,
  output logic rd_pulse,
  output logic [4:0] addr,
  output logic [11:0] wdata,
  input wire logic [11:0] rdata
);
  import tadc_pkg::*;

  logic cs_s1, cs_s2, cs_d, ck_s1, ck_s2, ck_d, di_s1, di_s2;
  logic rise, fall, is_write, load_q;
  logic [4:0] cnt;
  logic [16:0] sh_in;
  logic [11:0] sh_out;

  ////////////////////////////////////////////////////////////////////////
  // the serial clock is only sampled; nothing here runs on it
  always_ff @(posedge core_clk or posedge rst) begin // [RULE12]
    if (rst) begin
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      {ck_s1, ck_s2, ck_d} <= 3'h0;
      {di_s1, di_s2} <= 2'h0;
    end else begin
      cs_s1 <= cs_n_pin;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      ck_s1 <= sclk_pin;
      ck_s2 <= ck_s1;
      ck_d <= ck_s2;
      di_s1 <= sdi_pin;
      di_s2 <= di_s1;
    end
  end
  assign rise = ck_s2 & ~ck_d & ~cs_s2;
  assign fall = ~ck_s2 & ck_d & ~cs_s2;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_active <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      cs_active <= ~cs_s2;
      frame_start <= cs_d & ~cs_s2; // [RULE4]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input shifter; bits past the frame length are ignored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 5'h00;
      sh_in <= 17'h00000;
      is_write <= 1'b0;
      addr <= 5'h00;
      wdata <= 12'h000;
      wr_pulse <= 1'b0;
      load_q <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      load_q <= 1'b0;
      if (cs_s2) begin
        cnt <= 5'h00;
      end else if (rise && cnt < 5'(`TADC_FRAME_BITS)) begin // [RULE5]
        sh_in <= {sh_in[15:0], di_s2};
        cnt <= cnt + 5'h01;
        if (cnt == 5'(`TADC_HDR_BITS - 1)) begin // [RULE21]
          is_write <= sh_in[4];
          addr <= {sh_in[3:0], di_s2};
          load_q <= 1'b1;
        end
        if (cnt == 5'(`TADC_FRAME_BITS - 1) && is_write) begin
          wdata <= {sh_in[10:0], di_s2};
          wr_pulse <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output shifter, loaded one cycle after the header so addr is settled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sh_out <= 12'h000;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      rd_pulse <= 1'b0;
    end else begin
      rd_pulse <= load_q & ~is_write;
      sdo_oe <= ~cs_s2; // [RULE11]
      if (cs_s2) begin
        sdo <= 1'b0;
      end else if (load_q) begin
        sh_out <= is_write ? 12'h000 : rdata;
      end else if (fall) begin // [RULE11]
        sdo <= sh_out[11];
        sh_out <= {sh_out[10:0], 1'b0};
      end
    end
  end

  chk_sdo_float: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
    cs_s2 |-> ##1 !sdo_oe) else $error("serial output driven while deselected");
  chk_write_len: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
    wr_pulse |-> cnt == 5'(`TADC_FRAME_BITS)) else $error("write before full frame");
endmodule : tadc_serial_if

// file: tadc_top.sv
// conversion control and pin logic of the touch acquisition controller.
// assumes a converter macro on core_clk and pins asynchronous to it.
`timescale 1ns/1ps
`include "tadc_params.svh"
module tadc_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial pins
  input wire logic cs_n,
  input wire logic serial_clk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // status pins
  input wire logic pen_touch_in,
  output logic pen_touch_irq_n,
  output logic pen_touch_irq_oe,
  input wire logic acq_halt_in,
  output logic result_ready_n,
  output logic result_ready_oe,
  output logic alert_n,
  // logic pins: bits 0..2 aux_in_one..three, bit 3 dedicated_logic_pin
  input wire logic [3:0] logic_pin_in,
  output logic [3:0] logic_pin_out,
  output logic [3:0] logic_pin_oe,
  // converter macro
  output logic [3:0] adc_mux_sel,
  output logic adc_sample,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [11:0] adc_data
);
  import tadc_pkg::*;

  logic cs_active, frame_start, wr_pulse, rd_pulse;
  logic [4:0] addr;
  logic [11:0] wdata, rdata;
  logic [11:0] ctrl_reg, timing_reg, timer_reg, gpio_reg;
  logic [11:0] lim_hi [`TADC_NUM_LIM];
  logic [11:0] lim_lo [`TADC_NUM_LIM];
  logic [11:0] results [`TADC_NUM_RES];
  logic [3:0] lim_chan [`TADC_NUM_LIM];
  logic [3:0] oor;
  logic [3:0] pin_s1, pin_s2, gpio_data;
  logic halt_s1, halt_s2, pen_s1, pen_s2;
  logic [6:0] tick_cnt;
  logic tick;
  logic [11:0] interval_cnt;
  logic timer_fire, pend, ready_flag;
  tadc_state_type st;
  logic [3:0] code;
  logic [5:0] wait_cnt;
  logic [4:0] conv_cnt;
  logic [15:0] acc;
  logic [2:0] avg_l, avg_q;
  logic [4:0] avg_n;
  logic [5:0] pwr_delay, acq_time;

  // the host reaches every register through this slave only
  tadc_serial_if u_serial ( // [RULE20]
    .core_clk(core_clk),
    .rst(rst),
    .cs_n_pin(cs_n),
    .sclk_pin(serial_clk),
    .sdi_pin(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .cs_active(cs_active),
    .frame_start(frame_start),
    .wr_pulse(wr_pulse),
    .rd_pulse(rd_pulse),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `TADC_CTRL_RST;
      timing_reg <= `TADC_TIMING_RST;
      timer_reg <= `TADC_TIMER_RST;
      gpio_reg <= `TADC_GPIO_RST;
      for (int i = 0; i < `TADC_NUM_LIM; i++) begin
        lim_hi[i] <= `TADC_LIM_HI_RST;
        lim_lo[i] <= `TADC_LIM_LO_RST;
      end
    end else if (wr_pulse) begin
      case (addr)
        `TADC_A_CTRL: ctrl_reg <= wdata;
        `TADC_A_TIMING: timing_reg <= wdata;
        `TADC_A_TIMER: timer_reg <= wdata;
        `TADC_A_GPIO: gpio_reg <= wdata;
        default: begin
          for (int i = 0; i < `TADC_NUM_LIM; i++) begin
            if (addr == 5'(`TADC_A_LIM + 2 * i)) lim_hi[i] <= wdata;
            if (addr == 5'(`TADC_A_LIM + 2 * i + 1)) lim_lo[i] <= wdata;
          end
        end
      endcase
    end
  end

  // register reads; unmapped addresses read zero
  always_comb begin
    rdata = 12'h000;
    case (addr)
      `TADC_A_CTRL: rdata = ctrl_reg;
      `TADC_A_TIMING: rdata = timing_reg;
      `TADC_A_TIMER: rdata = timer_reg;
      `TADC_A_GPIO: rdata = {gpio_data, gpio_reg[7:0]};
      `TADC_A_ALERT: rdata = {8'h00, oor};
      default: begin
        for (int i = 0; i < `TADC_NUM_LIM; i++) begin
          if (addr == 5'(`TADC_A_LIM + 2 * i)) rdata = lim_hi[i];
          if (addr == 5'(`TADC_A_LIM + 2 * i + 1)) rdata = lim_lo[i];
        end
        for (int i = 0; i < `TADC_NUM_RES; i++) begin
          if (addr == 5'(`TADC_A_RES + i)) rdata = results[i]; // [RULE14]
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {halt_s1, halt_s2, pen_s1, pen_s2} <= 4'h0;
    end else begin
      halt_s1 <= acq_halt_in;
      halt_s2 <= halt_s1;
      pen_s1 <= pen_touch_in;
      pen_s2 <= pen_s1;
    end
  end

  // open-drain style: drive low on touch, the pull-up holds it high otherwise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pen_touch_irq_n <= 1'b1;
      pen_touch_irq_oe <= 1'b0;
    end else begin
      pen_touch_irq_n <= ~pen_s2; // [RULE3]
      pen_touch_irq_oe <= pen_s2; // [RULE3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // logic pins: gpio_reg[3:0] logic mode, [7:4] drive, [11:8] data out
  for (genvar g = 0; g < 4; g++) begin : g_pin
    // the dedicated pin is always in logic mode
    logic mode;
    assign mode = (g == 3) ? 1'b1 : gpio_reg[g]; // [RULE2] [RULE7]
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        pin_s1[g] <= 1'b0;
        pin_s2[g] <= 1'b0;
        logic_pin_out[g] <= 1'b0;
        logic_pin_oe[g] <= 1'b0;
      end else begin
        pin_s1[g] <= logic_pin_in[g];
        pin_s2[g] <= pin_s1[g];
        logic_pin_out[g] <= gpio_reg[8 + g];
        logic_pin_oe[g] <= mode & gpio_reg[4 + g];
      end
    end
    assign gpio_data[g] = mode & (gpio_reg[4 + g] ? gpio_reg[8 + g] : pin_s2[g]);
  end

  ////////////////////////////////////////////////////////////////////////
  // limit checks on aux one, temperature one and both batteries
  assign lim_chan[0] = `TADC_CH_AUX1;
  assign lim_chan[1] = `TADC_CH_TEMPERATURE_ONE;
  assign lim_chan[2] = `TADC_CH_BATTERY_IN_ONE;
  assign lim_chan[3] = `TADC_CH_BATTERY_IN_TWO;
  for (genvar g = 0; g < `TADC_NUM_LIM; g++) begin : g_lim
    assign oor[g] = (results[lim_chan[g]] > lim_hi[g]) // [RULE15]
      || (results[lim_chan[g]] < lim_lo[g]);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~((|oor) | (|gpio_data)); // [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one microsecond tick and the repeat timer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 7'h00;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 7'(`TADC_TICK_CYC - 1));
      tick_cnt <= (tick_cnt == 7'(`TADC_TICK_CYC - 1)) ? 7'h00 : tick_cnt + 7'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interval_cnt <= 12'h000;
      timer_fire <= 1'b0;
    end else begin
      timer_fire <= 1'b0;
      if (!ctrl_reg[`TADC_TMR_BIT]) begin
        interval_cnt <= 12'h000;
      end else if (tick) begin
        if (interval_cnt >= timer_reg) begin
          interval_cnt <= 12'h000;
          timer_fire <= 1'b1; // [RULE19]
        end else begin
          interval_cnt <= interval_cnt + 12'h001;
        end
      end
    end
  end

  // a start request waits in pend; a new request beats the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
    end else if (frame_start || timer_fire) begin
      pend <= 1'b1; // [RULE4] [RULE19]
    end else if (st == ST_PWRUP) begin
      pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  assign avg_l = (ctrl_reg[`TADC_AVG_LSB +: 3] > `TADC_AVG_MAX) ? `TADC_AVG_MAX
    : ctrl_reg[`TADC_AVG_LSB +: 3];
  // held per sequence: a ctrl write mid-average cannot strand the count
  assign avg_n = 5'h01 << avg_q; // [RULE16]
  assign pwr_delay = timing_reg[5:0];
  assign acq_time = timing_reg[11:6];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= ST_IDLE;
      code <= 4'h0;
      wait_cnt <= 6'h00;
      conv_cnt <= 5'h00;
      acc <= 16'h0000;
      adc_start <= 1'b0;
      avg_q <= 3'h0;
    end else begin
      adc_start <= 1'b0;
      case (st)
        ST_IDLE: begin
          wait_cnt <= 6'h00;
          conv_cnt <= 5'h00;
          acc <= 16'h0000;
          if (pend) begin
            avg_q <= avg_l;
            // host mode takes the programmed channel, auto starts at the first
            code <= ctrl_reg[`TADC_AUTO_BIT] ? `TADC_CH_XP // [RULE17]
              : ctrl_reg[`TADC_CHAN_LSB +: 4];
            st <= ST_PWRUP;
          end
        end
        ST_PWRUP: begin
          if (wait_cnt >= pwr_delay) begin // [RULE18]
            wait_cnt <= 6'h00;
            st <= ST_ACQ;
          end else if (tick) begin
            wait_cnt <= wait_cnt + 6'h01;
          end
        end
        ST_ACQ: begin
          // a halt aborts the acquisition, which restarts from zero
          if (halt_s2) begin
            wait_cnt <= 6'h00; // [RULE6]
          end else if (wait_cnt >= acq_time) begin // [RULE18]
            wait_cnt <= 6'h00;
            adc_start <= 1'b1;
            st <= ST_CONV;
          end else if (tick) begin
            wait_cnt <= wait_cnt + 6'h01;
          end
        end
        ST_CONV: begin
          if (adc_done) begin
            acc <= acc + {4'h0, adc_data}; // [RULE13]
            conv_cnt <= conv_cnt + 5'h01;
            st <= (conv_cnt + 5'h01 == avg_n) ? ST_STORE : ST_ACQ; // [RULE16]
          end
        end
        ST_STORE: begin
          conv_cnt <= 5'h00;
          acc <= 16'h0000;
          if (ctrl_reg[`TADC_AUTO_BIT] && code < `TADC_CH_LAST) begin
            code <= code + 4'h1; // [RULE17]
            st <= ST_ACQ;
          end else begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // results land in the register named by the channel code
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `TADC_NUM_RES; i++) results[i] <= 12'h000;
    end else if (st == ST_STORE && code <= `TADC_CH_LAST) begin
      results[code] <= 12'(acc >> avg_q); // [RULE14] [RULE13]
    end
  end

  // sampling switch follows the acquisition phase, cut by the halt pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      adc_sample <= 1'b0;
      adc_mux_sel <= `TADC_CH_XP;
    end else begin
      adc_sample <= (st == ST_ACQ) && !halt_s2; // [RULE6]
      adc_mux_sel <= code; // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // new data flag: a store beats a result read that clears it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready_flag <= 1'b0;
    end else if (st == ST_STORE) begin
      ready_flag <= 1'b1; // [RULE9]
    end else if (rd_pulse && addr >= `TADC_A_RES) begin
      ready_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_ready_n <= 1'b1;
      result_ready_oe <= 1'b0;
    end else begin
      result_ready_n <= ~ready_flag; // [RULE9]
      result_ready_oe <= cs_active; // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_halt_sample: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
    halt_s2 |-> ##1 !adc_sample) else $error("sampling during halt");
  chk_ready_float: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
    !cs_active |-> ##1 !result_ready_oe) else $error("ready driven while deselected");
  chk_ready_store: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
    st == ST_STORE |-> ##2 !result_ready_n) else $error("ready not low after store");
  chk_alert_limit: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
    (|oor) |=> !alert_n) else $error("alert missing on limit fault");
  chk_avg_count: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
    st == ST_STORE |-> conv_cnt == avg_n) else $error("wrong conversion count");
  chk_host_chan: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
    (st == ST_IDLE && pend && !ctrl_reg[`TADC_AUTO_BIT])
    |=> code == $past(ctrl_reg[`TADC_CHAN_LSB +: 4])) else $error("host channel not used");
  chk_pen_drive: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
    pen_s2 |=> pen_touch_irq_oe && !pen_touch_irq_n) else $error("pen not driven low");
  chk_mux_range: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    adc_start |=> adc_mux_sel <= `TADC_CH_LAST) else $error("mux code out of range");
endmodule : tadc_top

// file: tadc_host_model.sv
// host-side serial master model for the touch acquisition controller.
// assumes the caller enters frame() off the core clock edges.
`timescale 1ns/1ps
module tadc_host_model (
  // serial pins toward the device
  output logic cs_n,
  output logic serial_clk,
  output logic sdi,
  // serial pins from the device
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic last_bit;
  logic sdo_wire;
  ////////////////////////////////////////////////////////////////////////////
  // a released line keeps no value: show the inverse of the last driven bit
  always @* if (sdo_oe === 1'b1) last_bit = sdo;
  assign sdo_wire = (sdo_oe === 1'b1) ? sdo : ~last_bit;
  initial begin
    cs_n = 1'b1;
    serial_clk = 1'b0;
    sdi = 1'b0;
    last_bit = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one frame: write flag, address, data, msb first; clock stands low between
  task automatic frame(input logic wr, input logic [4:0] a, input logic [11:0] d,
      output logic [11:0] q);
    logic [17:0] sh;
    sh = {wr, a, d};
    q = 12'h000;
    cs_n = 1'b0;
    #40;
    for (int i = 17; i >= 0; i--) begin
      sdi = sh[i];
      #40 serial_clk = 1'b1;
      // sampled late in the high phase, before the device shifts again
      #39 if (i < 12) q = {q[10:0], sdo_wire};
      #1 serial_clk = 1'b0;
    end
    sdi = ~sdi;
    #40 cs_n = 1'b1;
    #80;
  endtask : frame
endmodule : tadc_host_model

// file: tadc_top_tb_top.sv
// self-checking bench of the touch acquisition controller.
// assumes a host model on the serial pins and a one-cycle converter model.
`timescale 1ns/1ps
`include "tadc_params.svh"
module tadc_top_tb_top;
  logic core_clk, rst, pen_touch_in, acq_halt_in, adc_done;
  logic cs_n, serial_clk, sdi, sdo, sdo_oe, pen_touch_irq_n, pen_touch_irq_oe;
  logic result_ready_n, result_ready_oe, alert_n, adc_sample, adc_start;
  logic [3:0] logic_pin_in, logic_pin_out, logic_pin_oe, adc_mux_sel, sel_q;
  logic [11:0] adc_data, nst, n0, q, rdy, r0;
  int num_errors, checks_done;
  ////////////////////////////////////////////////////////////////////////////
  tadc_top dut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .serial_clk(serial_clk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .pen_touch_in(pen_touch_in),
    .pen_touch_irq_n(pen_touch_irq_n), .pen_touch_irq_oe(pen_touch_irq_oe),
    .acq_halt_in(acq_halt_in), .result_ready_n(result_ready_n),
    .result_ready_oe(result_ready_oe), .alert_n(alert_n), .logic_pin_in(logic_pin_in),
    .logic_pin_out(logic_pin_out), .logic_pin_oe(logic_pin_oe), .adc_mux_sel(adc_mux_sel),
    .adc_sample(adc_sample), .adc_start(adc_start), .adc_done(adc_done),
    .adc_data(adc_data));
  tadc_host_model host (.cs_n(cs_n), .serial_clk(serial_clk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));
  ////////////////////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;
  // converter answers next cycle; each sample differs by two so averages show
  always @(posedge core_clk) begin
    adc_done <= adc_start;
    if (adc_start === 1'b1) begin
      nst <= nst + 12'h001;
      sel_q <= adc_mux_sel;
      adc_data <= 12'h100 + {nst[10:0], 1'b0};
    end
    if (result_ready_oe === 1'b1 && result_ready_n === 1'b0) rdy <= rdy + 12'h001;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [11:0] d);
    @(posedge core_clk);
    #3;
    host.frame(wr, a, d, q);
  endtask : xfer
  // wait until the converter has been quiet for 400 cycles
  task automatic settle;
    int i, s;
    logic [11:0] p;
    p = nst;
    s = 0;
    for (i = 0; i < 6000 && s < 400; i++) begin
      @(posedge core_clk);
      if (nst === p) s++;
      else begin
        s = 0;
        p = nst;
      end
    end
    if (s < 400) begin
      num_errors++;
      $display("BAD %0t: converter never idle", $time);
      results();
    end
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    pen_touch_in = 1'b0;
    acq_halt_in = 1'b0;
    adc_done = 1'b0;
    logic_pin_in = 4'h0;
    adc_data = 12'h000;
    nst = 12'h000;
    rdy = 12'h000;
    sel_q = 4'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check({7'h0, alert_n, pen_touch_irq_n, pen_touch_irq_oe, sdo_oe, result_ready_oe},
      12'h018);
    pen_touch_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    check({10'h0, pen_touch_irq_n, pen_touch_irq_oe}, 12'h001);
    pen_touch_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    check({10'h0, pen_touch_irq_n, pen_touch_irq_oe}, 12'h002);
    xfer(1'b1, `TADC_A_GPIO, 12'h891);
    check({4'h0, logic_pin_oe, logic_pin_out}, 12'h098);
    check({11'h0, alert_n}, 12'h000);
    xfer(1'b1, `TADC_A_GPIO, 12'h091);
    check({11'h0, alert_n}, 12'h001);
    xfer(1'b0, `TADC_A_GPIO, 12'h000);
    check(q, 12'h091);
    check({10'h0, sdo_oe, result_ready_oe}, 12'h000);
    // aux two as an undriven logic input: its pin level reads back and raises the alert
    @(posedge core_clk);
    logic_pin_in <= 4'h2;
    xfer(1'b1, `TADC_A_GPIO, 12'h002);
    xfer(1'b0, `TADC_A_GPIO, 12'h000);
    check(q, 12'h202);
    check({11'h0, alert_n}, 12'h000);
    @(posedge core_clk);
    logic_pin_in <= 4'h0;
    settle;
    xfer(1'b1, `TADC_A_CTRL, 12'h02c);
    settle;
    n0 = nst;
    xfer(1'b0, `TADC_A_ALERT, 12'h000);
    settle;
    check(nst - n0, 12'h002);
    check({8'h0, sel_q}, 12'h006);
    r0 = rdy;
    xfer(1'b0, `TADC_A_RES + 5'h06, 12'h000);
    check(q, 12'h101 + {n0[10:0], 1'b0});
    check({11'h0, rdy != r0}, 12'h001);
    // the read itself started a sequence; let it end so the halt count starts clean
    settle;
    @(posedge core_clk);
    acq_halt_in <= 1'b1;
    n0 = nst;
    xfer(1'b0, `TADC_A_ALERT, 12'h000);
    repeat (600) @(posedge core_clk);
    check(nst - n0, 12'h000);
    check({11'h0, adc_sample}, 12'h000);
    acq_halt_in <= 1'b0;
    settle;
    check(nst - n0, 12'h002);
    xfer(1'b1, `TADC_A_LIM, 12'h050);
    settle;
    xfer(1'b1, `TADC_A_CTRL, 12'h006);
    settle;
    xfer(1'b0, `TADC_A_ALERT, 12'h000);
    settle;
    check({8'h0, sel_q}, 12'h003);
    check({11'h0, alert_n}, 12'h000);
    xfer(1'b0, `TADC_A_ALERT, 12'h000);
    check(q, 12'h001);
    xfer(1'b1, `TADC_A_TIMER, 12'h004);
    xfer(1'b1, `TADC_A_CTRL, 12'h106);
    settle;
    n0 = nst;
    repeat (2000) @(posedge core_clk);
    check({11'h0, (nst - n0) > 12'h002}, 12'h001);
    results();
  end
endmodule : tadc_top_tb_top
